/* File: logic/bwrs_pkg.sv */
// Purpose: Shared constants and types of the byte write/read sequencer
// Assumes: ref_clk at 8 ns, link_clk at 32 ns
// Notes:   Slot times are plain defaults, tune per line load

package bwrs_pkg;

    // ------------------------------------------------------------
    // Command codes and sizes
    // ------------------------------------------------------------
    localparam logic [7:0] CMD_WRITE_BYTE = 8'ha5;
    localparam logic [7:0] CMD_READ_BYTE  = 8'h96;
    localparam int         BYTE_BITS      = 8;
    localparam logic [2:0] LAST_BIT       = 3'h7;
    localparam logic [7:0] READ_SLOT_PAT  = 8'hff;

    // ------------------------------------------------------------
    // Clocks and host-side latency bound
    // ------------------------------------------------------------
    localparam int  REF_CLK_NS  = 8;
    localparam int  LINK_CLK_NS = 32;
    localparam real ACT_MAX_NS  = 262.5;
    localparam int  ACT_MAX_CYC = $rtoi(ACT_MAX_NS / REF_CLK_NS);

    // ------------------------------------------------------------
    // Slot timing in ns, standard and high speed
    // ------------------------------------------------------------
    localparam int STD_SLOT_NS = 70000;
    localparam int STD_W0L_NS  = 60000;
    localparam int STD_W1L_NS  = 6000;
    localparam int STD_MSR_NS  = 15000;
    localparam int OD_SLOT_NS  = 10000;
    localparam int OD_W0L_NS   = 8000;
    localparam int OD_W1L_NS   = 1000;
    localparam int OD_MSR_NS   = 2000;

    // ------------------------------------------------------------
    // Slot timing in link clock cycles
    // ------------------------------------------------------------
    localparam int         CNT_W        = 12;
    localparam logic [11:0] STD_SLOT_CYC = 12'((STD_SLOT_NS + LINK_CLK_NS - 1) / LINK_CLK_NS);
    localparam logic [11:0] STD_W0L_CYC  = 12'((STD_W0L_NS + LINK_CLK_NS - 1) / LINK_CLK_NS);
    localparam logic [11:0] STD_W1L_CYC  = 12'((STD_W1L_NS + LINK_CLK_NS - 1) / LINK_CLK_NS);
    localparam logic [11:0] STD_MSR_CYC  = 12'(STD_MSR_NS / LINK_CLK_NS);
    localparam logic [11:0] OD_SLOT_CYC  = 12'((OD_SLOT_NS + LINK_CLK_NS - 1) / LINK_CLK_NS);
    localparam logic [11:0] OD_W0L_CYC   = 12'((OD_W0L_NS + LINK_CLK_NS - 1) / LINK_CLK_NS);
    localparam logic [11:0] OD_W1L_CYC   = 12'((OD_W1L_NS + LINK_CLK_NS - 1) / LINK_CLK_NS);
    localparam logic [11:0] OD_MSR_CYC   = 12'(OD_MSR_NS / LINK_CLK_NS);

    // Busy window seen in ref cycles, crossing slack included
    localparam int BUSY_MIN_CYC = BYTE_BITS * OD_SLOT_NS / REF_CLK_NS;
    localparam int BUSY_MAX_CYC = BYTE_BITS * 32'(STD_SLOT_CYC) * LINK_CLK_NS / REF_CLK_NS + 2 * ACT_MAX_CYC;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic       rd;
        logic       ovd;
        logic [7:0] data;
    } bwrs_job_t;

    typedef enum logic [3:0] {
        SEQ_IDLE  = 4'b0001,
        SEQ_WDATA = 4'b0010,
        SEQ_RARM  = 4'b0100,
        SEQ_BUSY  = 4'b1000
    } bwrs_seq_t;

    typedef enum logic [1:0] {
        SL_IDLE = 2'b01,
        SL_RUN  = 2'b10
    } bwrs_slot_st_t;

endpackage : bwrs_pkg

/* File: logic/bwrs_slot_engine.sv */
// Purpose: Link-side slot generator, eight slots per job
// Assumes: link_clk runs free; job stable while a request is pending
// Notes:   Open-drain line, enable high pulls low

`timescale 1ns/10ps
`default_nettype none

module bwrs_slot_engine (
    input  wire logic              link_clk,
    input  wire logic              rst,
    input  wire logic              req_tgl,
    input  wire bwrs_pkg::bwrs_job_t job,
    output logic                   done_tgl,
    output logic [7:0]             rx_byte,
    input  wire logic              line_i,
    output logic                   line_o,
    output logic                   line_oe
);

    // ------------------------------------------------------------
    // Synchronisers
    // ------------------------------------------------------------
    logic rst_m_q, rst_q;
    logic req_s1_q, req_s2_q, req_s3_q;
    logic line_s1_q, line_s2_q;

    always_ff @(posedge link_clk) begin
        rst_m_q   <= rst;
        rst_q     <= rst_m_q;
        req_s1_q  <= req_tgl;
        req_s2_q  <= req_s1_q;
        req_s3_q  <= req_s2_q;
        line_s1_q <= line_i;
        line_s2_q <= line_s1_q;
    end

    // ------------------------------------------------------------
    // Slot sequencer
    // ------------------------------------------------------------
    bwrs_pkg::bwrs_slot_st_t st_q, st_d;
    logic [11:0] cnt_q, cnt_d;
    logic [2:0]  bit_q, bit_d;
    logic [7:0]  tx_q, tx_d, rx_q, rx_d;
    logic        ovd_q, ovd_d, done_q, done_d, oe_q, oe_d;
    logic [11:0] slot_len, low_len, msr_pt;
    logic        start, sample;

    always_comb begin
        start   = req_s2_q ^ req_s3_q;
        slot_len = ovd_q ? bwrs_pkg::OD_SLOT_CYC : bwrs_pkg::STD_SLOT_CYC;
        msr_pt   = ovd_q ? bwrs_pkg::OD_MSR_CYC : bwrs_pkg::STD_MSR_CYC;
        if (tx_q[0])
            low_len = ovd_q ? bwrs_pkg::OD_W1L_CYC : bwrs_pkg::STD_W1L_CYC;
        else
            low_len = ovd_q ? bwrs_pkg::OD_W0L_CYC : bwrs_pkg::STD_W0L_CYC;
        sample = (st_q == bwrs_pkg::SL_RUN) && (cnt_q == msr_pt - 12'h001);
        st_d   = st_q;
        cnt_d  = cnt_q;
        bit_d  = bit_q;
        tx_d   = tx_q;
        rx_d   = rx_q;
        ovd_d  = ovd_q;
        done_d = done_q;
        oe_d   = oe_q;
        case (st_q)
            bwrs_pkg::SL_IDLE: begin
                oe_d = 1'b0;
                if (start) begin
                    st_d  = bwrs_pkg::SL_RUN;
                    cnt_d = '0;
                    bit_d = '0;
                    // Reads are write-one slots
                    tx_d  = job.rd ? bwrs_pkg::READ_SLOT_PAT : job.data;
                    ovd_d = job.ovd;
                    oe_d  = 1'b1;
                end
            end
            bwrs_pkg::SL_RUN: begin
                cnt_d = cnt_q + 12'h001;
                oe_d  = (cnt_q + 12'h001) < low_len;
                if (sample)
                    rx_d = {line_s2_q, rx_q[7:1]};
                if (cnt_q == slot_len - 12'h001) begin
                    cnt_d = '0;
                    tx_d  = {1'b0, tx_q[7:1]};
                    bit_d = bit_q + 3'h1;
                    oe_d  = 1'b1;
                    if (bit_q == bwrs_pkg::LAST_BIT) begin
                        st_d   = bwrs_pkg::SL_IDLE;
                        oe_d   = 1'b0;
                        done_d = ~done_q;
                    end
                end
            end
            default: begin
                st_d = bwrs_pkg::SL_IDLE;
                oe_d = 1'b0;
            end
        endcase
    end

    always_ff @(posedge link_clk) begin
        if (rst_q) begin
            st_q   <= bwrs_pkg::SL_IDLE;
            cnt_q  <= '0;
            bit_q  <= '0;
            tx_q   <= '0;
            rx_q   <= '0;
            ovd_q  <= 1'b0;
            done_q <= 1'b0;
            oe_q   <= 1'b0;
        end else begin
            st_q   <= st_d;
            cnt_q  <= cnt_d;
            bit_q  <= bit_d;
            tx_q   <= tx_d;
            rx_q   <= rx_d;
            ovd_q  <= ovd_d;
            done_q <= done_d;
            oe_q   <= oe_d;
        end
    end

    assign done_tgl = done_q;
    assign rx_byte  = rx_q;
    assign line_o   = 1'b0;
    assign line_oe  = oe_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_sample_shift: assert property (@(posedge link_clk) disable iff (rst_q)
        sample |=> rx_q[7] == $past(line_s2_q))
        else $error("sampled bit not shifted in");

    a_slot_low_first: assert property (@(posedge link_clk) disable iff (rst_q)
        (st_q == bwrs_pkg::SL_RUN && cnt_q == 12'h000) |-> oe_q)
        else $error("slot did not open with a low");

endmodule : bwrs_slot_engine

`default_nettype wire

/* File: logic/bwrs_top.sv */
// What this block does
// - Write code plus byte sends eight slots
// - Busy: write code and byte not acknowledged
// - Write slots start within bound after byte
// - Busy lasts eight slots, bounded command time
// - Accepted command points reads at status
// - Read code makes eight write-one slots
// - Busy: read code not acknowledged
// - Read slots start within bound after ack
// - Line sampled at master sample time
//
// Purpose: Byte command engine between host byte port and single-wire line
// Assumes: Host front end on ref_clk; link_clk free running, 32 ns
// Notes:   Job and result words cross by toggle handshake

`timescale 1ns/10ps
`default_nettype none

module bwrs_top #(
    parameter int BYTE_W = 8
) (
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic        link_clk,
    input  wire logic        hb_byte_valid,
    input  wire logic [7:0]  hb_byte,
    input  wire logic        hb_is_cmd,
    input  wire logic        hb_cmd_ack_fall,
    output logic             hb_ack,
    output logic             ptr_to_status,
    output logic             line_busy_flag,
    output logic [7:0]       read_data,
    input  wire logic        overspeed_select,
    input  wire logic        line_i,
    output logic             line_o,
    output logic             line_oe
);

    // ------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------
    if (BYTE_W != bwrs_pkg::BYTE_BITS) begin : g_bad_width
        $error("bwrs_top serves 8-bit bytes only");
    end

    // ------------------------------------------------------------
    // Return path from the link domain
    // ------------------------------------------------------------
    logic       done_tgl;
    logic [7:0] rx_byte;
    logic       done_s1_q, done_s2_q, done_s3_q;
    logic       done_ev;

    always_ff @(posedge ref_clk) begin
        done_s1_q <= done_tgl;
        done_s2_q <= done_s1_q;
        done_s3_q <= done_s2_q;
    end

    assign done_ev = done_s2_q ^ done_s3_q;

    // ------------------------------------------------------------
    // Command sequencer
    // ------------------------------------------------------------
    bwrs_pkg::bwrs_seq_t seq_q, seq_d;
    bwrs_pkg::bwrs_job_t job_q, job_d;
    logic       req_q, req_d;
    logic       ptr_q, ptr_d;
    logic       busy_q, busy_d;
    logic [7:0] rdat_q, rdat_d;
    logic       code_wr, code_rd, ack_c;

    always_comb begin
        code_wr = hb_byte_valid && hb_is_cmd && (hb_byte == bwrs_pkg::CMD_WRITE_BYTE);
        code_rd = hb_byte_valid && hb_is_cmd && (hb_byte == bwrs_pkg::CMD_READ_BYTE);
        seq_d   = seq_q;
        job_d   = job_q;
        req_d   = req_q;
        ptr_d   = 1'b0;
        busy_d  = busy_q;
        rdat_d  = rdat_q;
        ack_c   = 1'b0;
        case (seq_q)
            bwrs_pkg::SEQ_IDLE: begin
                if (code_wr) begin
                    ack_c = 1'b1;
                    ptr_d = 1'b1;
                    seq_d = bwrs_pkg::SEQ_WDATA;
                end else if (code_rd) begin
                    ack_c  = 1'b1;
                    ptr_d  = 1'b1;
                    busy_d = 1'b1;
                    seq_d  = bwrs_pkg::SEQ_RARM;
                end
            end
            bwrs_pkg::SEQ_WDATA: begin
                if (hb_byte_valid && !hb_is_cmd) begin
                    // Launch on the data byte, in the same cycle as its acknowledge
                    ack_c  = 1'b1;
                    job_d  = '{rd: 1'b0, ovd: overspeed_select, data: hb_byte};
                    req_d  = ~req_q;
                    busy_d = 1'b1;
                    seq_d  = bwrs_pkg::SEQ_BUSY;
                end else if (hb_byte_valid) begin
                    // A new code abandons the pending write
                    seq_d = bwrs_pkg::SEQ_IDLE;
                end
            end
            bwrs_pkg::SEQ_RARM: begin
                if (hb_cmd_ack_fall) begin
                    job_d = '{rd: 1'b1, ovd: overspeed_select, data: bwrs_pkg::READ_SLOT_PAT};
                    req_d = ~req_q;
                    seq_d = bwrs_pkg::SEQ_BUSY;
                end
            end
            bwrs_pkg::SEQ_BUSY: begin
                // Codes arriving now get no acknowledge and are dropped
                ack_c = 1'b0;
                if (done_ev) begin
                    if (job_q.rd)
                        rdat_d = rx_byte;
                    busy_d = 1'b0;
                    seq_d  = bwrs_pkg::SEQ_IDLE;
                end
            end
            default: begin
                seq_d  = bwrs_pkg::SEQ_IDLE;
                busy_d = 1'b0;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            seq_q  <= bwrs_pkg::SEQ_IDLE;
            job_q  <= '0;
            req_q  <= 1'b0;
            ptr_q  <= 1'b0;
            busy_q <= 1'b0;
            rdat_q <= '0;
        end else begin
            seq_q  <= seq_d;
            job_q  <= job_d;
            req_q  <= req_d;
            ptr_q  <= ptr_d;
            busy_q <= busy_d;
            rdat_q <= rdat_d;
        end
    end

    assign hb_ack         = ack_c;
    assign ptr_to_status  = ptr_q;
    assign line_busy_flag = busy_q;
    assign read_data      = rdat_q;

    // ------------------------------------------------------------
    // Link-side slot engine
    // ------------------------------------------------------------
    bwrs_slot_engine u_slots (
        .link_clk (link_clk),
        .rst      (rst),
        .req_tgl  (req_q),
        .job      (job_q),
        .done_tgl (done_tgl),
        .rx_byte  (rx_byte),
        .line_i   (line_i),
        .line_o   (line_o),
        .line_oe  (line_oe)
    );

    // ------------------------------------------------------------
    // Helper: length of the busy window
    // ------------------------------------------------------------
    logic [17:0] busy_len_q, busy_len_d;

    always_comb begin
        busy_len_d = busy_q ? busy_len_q + 18'h00001 : 18'h00000;
    end

    always_ff @(posedge ref_clk) begin
        if (rst)
            busy_len_q <= '0;
        else
            busy_len_q <= busy_len_d;
    end

    localparam int ACT_LIM = bwrs_pkg::ACT_MAX_CYC;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_write_code_ack: assert property (@(posedge ref_clk) disable iff (rst)
        (seq_q == bwrs_pkg::SEQ_IDLE && code_wr) |-> hb_ack ##1 seq_q == bwrs_pkg::SEQ_WDATA)
        else $error("idle write code not taken");

    a_busy_no_ack: assert property (@(posedge ref_clk) disable iff (rst)
        (line_busy_flag && hb_byte_valid) |-> !hb_ack)
        else $error("acknowledge given while busy");

    a_read_busy_drop: assert property (@(posedge ref_clk) disable iff (rst)
        (line_busy_flag && code_rd && !done_ev) |=> $stable(req_q) && line_busy_flag)
        else $error("read code acted on while busy");

    a_write_launch: assert property (@(posedge ref_clk) disable iff (rst)
        (seq_q == bwrs_pkg::SEQ_WDATA && hb_byte_valid && !hb_is_cmd) |=> $changed(req_q)
            ##[1:ACT_LIM] line_oe)
        else $error("write slots late");

    a_read_launch: assert property (@(posedge ref_clk) disable iff (rst)
        (seq_q == bwrs_pkg::SEQ_RARM && hb_cmd_ack_fall) |=> $changed(req_q) ##[1:ACT_LIM] line_oe)
        else $error("read slots late");

    a_busy_window: assert property (@(posedge ref_clk) disable iff (rst)
        $fell(busy_q) |-> ($past(busy_len_q) >= 18'(bwrs_pkg::BUSY_MIN_CYC))
            && ($past(busy_len_q) <= 18'(bwrs_pkg::BUSY_MAX_CYC)))
        else $error("busy window out of range");

    a_ptr_status: assert property (@(posedge ref_clk) disable iff (rst)
        (seq_q == bwrs_pkg::SEQ_IDLE && (code_wr || code_rd)) |=> ptr_to_status ##1 !ptr_to_status)
        else $error("pointer not moved to status");

    a_read_store: assert property (@(posedge ref_clk) disable iff (rst)
        (seq_q == bwrs_pkg::SEQ_BUSY && done_ev && job_q.rd) |=> read_data == $past(rx_byte))
        else $error("read byte not stored");

    a_write_keeps: assert property (@(posedge ref_clk) disable iff (rst)
        (seq_q == bwrs_pkg::SEQ_BUSY && done_ev && !job_q.rd) |=> $stable(read_data))
        else $error("write changed read data");

    c_write_done: cover property (@(posedge ref_clk) disable iff (rst)
        seq_q == bwrs_pkg::SEQ_BUSY && done_ev && !job_q.rd);

    c_read_done: cover property (@(posedge ref_clk) disable iff (rst)
        seq_q == bwrs_pkg::SEQ_BUSY && done_ev && job_q.rd);

    c_refused: cover property (@(posedge ref_clk) disable iff (rst)
        line_busy_flag && (code_wr || code_rd));

    c_overspeed: cover property (@(posedge ref_clk) disable iff (rst)
        $fell(busy_q) && job_q.ovd);

endmodule : bwrs_top

`default_nettype wire

/* File: verif/bwrs_slave_model.sv */
// Purpose: Behavioural slave on the single-wire line for the sequencer bench
// Assumes: Pulled-up line, master fall opens each slot
// Notes:   Answer delay is an input so one slave can reply fast or slow

`timescale 1ns/10ps
`default_nettype none

module bwrs_slave_model #(
    parameter int ZERO_MIN_NS = 4000,
    parameter int HOLD_NS     = 4000
) (
    input  wire logic        line,
    input  wire logic [7:0]  tx_byte,
    input  wire logic        tx_en,
    input  wire logic [15:0] resp_ns,
    output logic             pull,
    output logic [7:0]       rx_byte,
    output logic [7:0]       slot_cnt
);
    logic [2:0] idx;
    logic       bit_v;
    realtime    t0;

    initial begin
        pull     = 1'b0;
        rx_byte  = 8'h00;
        slot_cnt = 8'h00;
        idx      = 3'h0;
    end

    always @(posedge tx_en) begin
        idx = 3'h0;
    end

    // ------------------------------------------------------------
    // One slot per master fall
    // ------------------------------------------------------------
    always @(negedge line) begin
        t0 = $realtime;
        // Zero answer: pull inside the master low, release after hold
        if (tx_en && !tx_byte[idx]) begin
            #(resp_ns) pull = 1'b1;
            #(HOLD_NS - resp_ns) pull = 1'b0;
        end
        wait (line === 1'b1);
        // Short low reads as one, long low as zero; first slot ends at bit 0
        bit_v    = (($realtime - t0) < ZERO_MIN_NS);
        rx_byte  = {bit_v, rx_byte[7:1]};
        slot_cnt = slot_cnt + 8'h01;
        idx      = idx + 3'h1;
    end

endmodule : bwrs_slave_model

`default_nettype wire

/* File: verif/bwrs_top_tb.sv */
// Purpose: Self-checking bench of the byte write/read sequencer
// Assumes: Fast slot timing, except one standard write cut short by reset
// Notes:   Line level is resolved here from both pull-downs and the pull-up

`timescale 1ns/10ps
`default_nettype none

`define CHK(nm, exp, got) \
    begin \
        comparisons++; \
        if ((got) !== (exp)) begin \
            bad_count++; \
            $display("mismatch %s expected %0h seen %0h", nm, exp, got); \
        end \
    end

module bwrs_top_tb;
    localparam int ACT_LIM  = bwrs_pkg::ACT_MAX_CYC + 1;
    localparam int BUSY_LO  = bwrs_pkg::BYTE_BITS * bwrs_pkg::OD_SLOT_NS / bwrs_pkg::REF_CLK_NS;
    localparam int BUSY_HI  = 8 * 313 * 4 + 2 * bwrs_pkg::ACT_MAX_CYC + 8;
    localparam int WD_CYC   = 60000;

    logic        ref_clk;
    logic        link_clk;
    logic        rst;
    logic        hb_byte_valid;
    logic [7:0]  hb_byte;
    logic        hb_is_cmd;
    logic        hb_cmd_ack_fall;
    logic        hb_ack;
    logic        ptr_to_status;
    logic        line_busy_flag;
    logic [7:0]  read_data;
    logic        line_o;
    logic        line_oe;
    logic        line_lvl;
    logic        ovs;
    logic        pull;
    logic [7:0]  tx_byte;
    logic        tx_en;
    logic [15:0] resp_ns;
    logic [7:0]  rx_byte;
    logic [7:0]  slot_cnt;
    int          bad_count   = 0;
    int          comparisons = 0;
    int          busy_run    = 0;
    int          busy_last   = 0;
    int          oe_run      = 0;
    int          oe_max      = 0;

    // Open-drain line with pull-up
    assign line_lvl = !(((line_oe === 1'b1) && (line_o === 1'b0)) || pull);

    bwrs_top uut (
        .ref_clk         (ref_clk),
        .rst             (rst),
        .link_clk        (link_clk),
        .hb_byte_valid   (hb_byte_valid),
        .hb_byte         (hb_byte),
        .hb_is_cmd       (hb_is_cmd),
        .hb_cmd_ack_fall (hb_cmd_ack_fall),
        .hb_ack          (hb_ack),
        .ptr_to_status   (ptr_to_status),
        .line_busy_flag  (line_busy_flag),
        .read_data       (read_data),
        .overspeed_select(ovs),
        .line_i          (line_lvl),
        .line_o          (line_o),
        .line_oe         (line_oe)
    );

    bwrs_slave_model slave (
        .line    (line_lvl),
        .tx_byte (tx_byte),
        .tx_en   (tx_en),
        .resp_ns (resp_ns),
        .pull    (pull),
        .rx_byte (rx_byte),
        .slot_cnt(slot_cnt)
    );

    // ------------------------------------------------------------
    // Clocks and run-length monitors
    // ------------------------------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    // Odd offset keeps the two clocks out of phase
    initial begin
        link_clk = 1'b0;
        #3.7;
        forever #16 link_clk = ~link_clk;
    end

    always @(posedge ref_clk) begin
        if (line_busy_flag === 1'b1) begin
            busy_run++;
        end else if (busy_run != 0) begin
            busy_last = busy_run;
            busy_run  = 0;
        end
    end

    always @(posedge link_clk) begin
        if (line_oe === 1'b1) begin
            oe_run++;
        end else begin
            if (oe_run > oe_max) oe_max = oe_run;
            oe_run = 0;
        end
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic put(input logic [7:0] b, input logic c, input logic ea);
        @(posedge ref_clk);
        #1;
        hb_byte_valid = 1'b1;
        hb_byte       = b;
        hb_is_cmd     = c;
        #5;
        `CHK("hb_ack", ea, hb_ack)
        @(posedge ref_clk);
        #1;
        hb_byte_valid = 1'b0;
        hb_is_cmd     = 1'b0;
    endtask : put

    task automatic wait_act(output int n);
        n = 0;
        while (line_oe !== 1'b1 && n < 200) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
    endtask : wait_act

    task automatic wait_idle();
        int n;
        n = 0;
        while (line_busy_flag === 1'b1 && n < BUSY_HI + 100) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        repeat (4) @(posedge ref_clk);
        #1;
    endtask : wait_idle

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : finish_test

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic abort_test();
        logic [7:0] c0;
        c0 = slot_cnt;
        put(bwrs_pkg::CMD_WRITE_BYTE, 1'b1, 1'b1);
        put(bwrs_pkg::CMD_READ_BYTE, 1'b1, 1'b0);
        `CHK("busy_after_abort", 1'b0, line_busy_flag)
        put(8'h3c, 1'b1, 1'b0);
        repeat (100) @(posedge ref_clk);
        `CHK("slots_after_abort", c0, slot_cnt)
    endtask : abort_test

    task automatic write_test();
        logic [7:0] c0;
        int         n;
        c0    = slot_cnt;
        tx_en = 1'b0;
        put(bwrs_pkg::CMD_WRITE_BYTE, 1'b1, 1'b1);
        `CHK("ptr_write", 1'b1, ptr_to_status)
        put(8'h35, 1'b0, 1'b1);
        `CHK("busy_write", 1'b1, line_busy_flag)
        wait_act(n);
        `CHK("act_write", 1'b1, n <= ACT_LIM)
        // Commands arriving while the line is busy must be dropped
        put(bwrs_pkg::CMD_READ_BYTE, 1'b1, 1'b0);
        `CHK("ptr_refused", 1'b0, ptr_to_status)
        put(bwrs_pkg::CMD_WRITE_BYTE, 1'b1, 1'b0);
        put(8'hc3, 1'b0, 1'b0);
        wait_idle();
        `CHK("busy_len_write", 1'b1, busy_last >= BUSY_LO && busy_last <= BUSY_HI)
        `CHK("slave_rx", 8'h35, rx_byte)
        repeat (100) @(posedge ref_clk);
        `CHK("write_slots", 8'(c0 + 8'h08), slot_cnt)
    endtask : write_test

    task automatic read_test(input logic [7:0] pat, input logic [15:0] dly);
        logic [7:0] c0;
        int         n;
        c0      = slot_cnt;
        tx_byte = pat;
        resp_ns = dly;
        tx_en   = 1'b1;
        oe_max  = 0;
        put(bwrs_pkg::CMD_READ_BYTE, 1'b1, 1'b1);
        `CHK("ptr_read", 1'b1, ptr_to_status)
        `CHK("busy_read", 1'b1, line_busy_flag)
        hb_cmd_ack_fall = 1'b1;
        @(posedge ref_clk);
        #1;
        hb_cmd_ack_fall = 1'b0;
        wait_act(n);
        `CHK("act_read", 1'b1, n <= ACT_LIM)
        wait_idle();
        // Host reads the data register only after busy clears
        `CHK("read_data", pat, read_data)
        `CHK("busy_len_read", 1'b1, busy_last >= BUSY_LO && busy_last <= BUSY_HI)
        `CHK("read_slots", 8'(c0 + 8'h08), slot_cnt)
        `CHK("short_lows", 1'b1, oe_max <= int'(bwrs_pkg::OD_W1L_CYC) + 1)
        tx_en = 1'b0;
    endtask : read_test

    // Standard speed would take too long in full; one slot low is timed, then reset cuts the job
    task automatic std_test();
        int n;
        ovs = 1'b0;
        put(bwrs_pkg::CMD_WRITE_BYTE, 1'b1, 1'b1);
        put(8'h00, 1'b0, 1'b1);
        wait_act(n);
        `CHK("act_std", 1'b1, n <= ACT_LIM)
        n = 0;
        while (line_oe === 1'b1 && n < 8000) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        `CHK("std_w0_low", 1'b1, n >= int'(bwrs_pkg::STD_W0L_CYC) * 4 - 8 && n <= int'(bwrs_pkg::STD_W0L_CYC) * 4 + 8)
        rst = 1'b1;
        repeat (12) @(posedge ref_clk);
        #1;
        rst = 1'b0;
        ovs = 1'b1;
        @(posedge ref_clk);
        #1;
        `CHK("busy_after_rst", 1'b0, line_busy_flag)
        repeat (16) @(posedge ref_clk);
        #1;
        `CHK("oe_after_rst", 1'b0, line_oe)
    endtask : std_test

    // ------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        rst             = 1'b1;
        hb_byte_valid   = 1'b0;
        hb_byte         = 8'h00;
        hb_is_cmd       = 1'b0;
        hb_cmd_ack_fall = 1'b0;
        tx_byte         = 8'hff;
        tx_en           = 1'b0;
        resp_ns         = 16'h0032;
        ovs             = 1'b1;
        repeat (12) @(posedge ref_clk);
        #1;
        rst = 1'b0;
        repeat (16) @(posedge ref_clk);
        abort_test();
        write_test();
        std_test();
        read_test(8'ha6, 16'h0032);
        read_test(8'h0f, 16'h0258);
        finish_test();
    end

    // Sized for four commands, three fast and one standard write cut short, with generous slack
    initial begin
        #(WD_CYC * bwrs_pkg::REF_CLK_NS);
        bad_count++;
        $display("mismatch watchdog expected done seen hang");
        finish_test();
    end

endmodule : bwrs_top_tb

`default_nettype wire
